// ---- casf_pkg.sv ----
// casf_pkg: constants and types for the core address space and fetch block
// assumes one 100 MHz system clock; the core clock is a prescaled tick of it
//
// Behaviour
// - on-chip fetches carry two bytes, external fetches one, over a 16-bit path
// - page mode: fetch in same 256-byte page takes two clocks, else four
// - on-chip fetch completes every state, allowing one instruction per state
// - external fetches allow one instruction per two states on a page miss, one per state on a page-mode hit
// - a state is two core clocks, phase one then phase two
// - peripheral cycle is six states, each clock labelled by state and phase
// - core clock is a tick from a run-time programmable oscillator prescaler
// - reset pin or watchdog expiry puts the core into its reset state
// - sources enabled singly with four priority levels; trap and NMI always enabled
// - a granted request abandons the fetch and branches to the source's routine
// - memory is one flat 24-bit space of 256 regions, no segments
// - on-chip code memory decodes in the topmost 64-Kbyte region
// - on-chip RAM starts at address zero; first 32 bytes hold the banks
// - register locations 0 to 7 map to RAM; 8 to 63 only in register file
// - status word bank bits choose which of four banks sits at locations 0-7
// - register file accessed as bytes, words and double words
// - separate 512-location special function register space decoded apart from memory
// - legacy low 128 bytes direct and indirect; bit addressing covers 20h-2Fh
// - legacy upper 128 bytes indirect only; direct there selects special function registers
// - legacy code reads via code move only; external data via external move only
`default_nettype none
package casf_pkg;
    // address space
    localparam int          ADDR_W       = 24;
    localparam logic [7:0]  CODE_REGION  = 8'hFF;
    localparam logic [5:0]  RF_BANKED    = 6'h08;
    localparam logic [7:0]  LEG_BIT_BASE = 8'h20;
    // access widths
    localparam logic [1:0]  W_BYTE       = 2'h0;
    localparam logic [1:0]  W_WORD       = 2'h1;
    localparam logic [1:0]  W_DWORD      = 2'h2;
    // timing in core clocks, and first and last state numbers
    localparam logic [2:0]  FETCH_CLK_ONCHIP = 3'h2;
    localparam logic [2:0]  FETCH_CLK_HIT    = 3'h2;
    localparam logic [2:0]  FETCH_CLK_MISS   = 3'h4;
    localparam logic [2:0]  STATE_FIRST      = 3'h1;
    localparam logic [2:0]  STATE_LAST       = 3'h6;
    // kinds of data access
    typedef enum logic [2:0] {
        ACC_LINEAR, ACC_REGFILE, ACC_SFR, ACC_LEG_DIRECT,
        ACC_LEG_INDIRECT, ACC_LEG_BIT, ACC_CODE_MOVE, ACC_EXT_MOVE
    } casf_acc_type;
    typedef enum logic {F_IDLE, F_BUSY} casf_fetch_type;
endpackage
`default_nettype wire

// ---- casf_core.sv ----
// casf_core: core clocking, reset, instruction fetch, address decode, interrupt grant
// assumes memory data and the data bus arrive from logic on sys_clk_in; reset pin is asynchronous
`default_nettype none
module casf_core
    import casf_pkg::*;
#(
    parameter int unsigned N_IRQ    = 8,
    parameter logic [23:0] RAM_SIZE = 24'h000800,
    parameter logic [23:0] VEC_BASE = 24'hFF0000,
    parameter logic [23:0] VEC_STEP = 24'h000008
) (
    // clock and reset
    input  wire logic               sys_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               rst_pin_n_in,
    input  wire logic               wdt_expire_in,
    // core clocking
    input  wire logic [7:0]         presc_div_in,
    output logic                    core_tick_out,
    output logic                    phase_out,
    output logic [2:0]              state_num_out,
    output logic                    core_rst_out,
    // instruction fetch
    input  wire logic               page_mode_in,
    input  wire logic               fetch_req_in,
    input  wire logic [23:0]        fetch_addr_in,
    input  wire logic [15:0]        code_data_in,
    input  wire logic [7:0]         ext_data_in,
    output logic [23:0]             fetch_addr_out,
    output logic                    code_rd_out,
    output logic                    ext_rd_out,
    output logic [15:0]             instr_out,
    output logic                    instr_valid_out,
    output logic                    instr_two_out,
    // data address decode
    input  wire logic               dec_req_in,
    input  wire casf_acc_type       acc_kind_in,
    input  wire logic [23:0]        acc_addr_in,
    input  wire logic [5:0]         rf_loc_in,
    input  wire logic [1:0]         acc_width_in,
    input  wire logic [1:0]         psw_bank_in,
    input  wire logic [7:0]         dpx_region_in,
    output logic                    dec_valid_out,
    output logic                    sel_ram_out,
    output logic                    sel_code_out,
    output logic                    sel_ext_out,
    output logic                    sel_sfr_out,
    output logic                    sel_rf_out,
    output logic [23:0]             map_addr_out,
    output logic [2:0]              bit_pos_out,
    output logic                    map_err_out,
    // interrupts
    input  wire logic [N_IRQ-1:0]   irq_in,
    input  wire logic [N_IRQ-1:0]   irq_en_in,
    input  wire logic [2*N_IRQ-1:0] irq_prio_in,
    input  wire logic               trap_in,
    input  wire logic               nmi_in,
    input  wire logic               irq_done_in,
    output logic                    irq_grant_out,
    output logic [$clog2(N_IRQ+2)-1:0] irq_src_out,
    output logic [23:0]             irq_vec_out
);
    localparam int SRC_W = $clog2(N_IRQ + 2);
    localparam logic [SRC_W-1:0] NMI_IDX  = SRC_W'(N_IRQ);
    localparam logic [SRC_W-1:0] TRAP_IDX = SRC_W'(N_IRQ + 1);

    // reset: pin synchroniser, watchdog, held core reset
    logic psync1_reg, psync2_reg, core_rst_reg, core_rst_next, hold;
    always_comb begin
        core_rst_next = !psync2_reg || wdt_expire_in;
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            psync1_reg   <= 1'b0;
            psync2_reg   <= 1'b0;
            core_rst_reg <= 1'b1;
        end else begin
            psync1_reg   <= rst_pin_n_in;
            psync2_reg   <= psync1_reg;
            core_rst_reg <= core_rst_next;
        end
    end
    assign hold = !rst_n_in || core_rst_reg;

    // prescaler tick, phase and state labels
    logic [7:0] pcnt_reg, pcnt_next;
    logic       tick_reg, tick_next, phase_reg, phase_next;
    logic [2:0] state_reg, state_next;
    always_comb begin
        tick_next  = (pcnt_reg >= presc_div_in);
        pcnt_next  = tick_next ? 8'h00 : pcnt_reg + 8'h01;
        phase_next = phase_reg;
        state_next = state_reg;
        if (tick_reg) begin
            phase_next = !phase_reg;
            if (phase_reg)
                state_next = (state_reg == STATE_LAST) ? STATE_FIRST : state_reg + 3'h1;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (hold) begin
            pcnt_reg  <= 8'h00;
            tick_reg  <= 1'b0;
            phase_reg <= 1'b0;
            state_reg <= STATE_FIRST;
        end else begin
            pcnt_reg  <= pcnt_next;
            tick_reg  <= tick_next;
            phase_reg <= phase_next;
            state_reg <= state_next;
        end
    end

    // interrupt qualification per source
    logic [N_IRQ-1:0] qual;
    for (genvar g = 0; g < N_IRQ; g++) begin : g_qual
        assign qual[g] = irq_in[g] && irq_en_in[g];
    end

    // interrupt priority search and grant
    logic             found, grant_now, ibusy_reg, ibusy_next, grant_reg;
    logic [1:0]       best_pr;
    logic [SRC_W-1:0] best_src, src_reg, src_next;
    logic [23:0]      vec_reg, vec_next;
    always_comb begin
        found    = 1'b0;
        best_pr  = 2'h0;
        best_src = '0;
        for (int i = 0; i < N_IRQ; i++) begin
            if (qual[i] && (!found || irq_prio_in[2*i +: 2] > best_pr)) begin
                found    = 1'b1;
                best_pr  = irq_prio_in[2*i +: 2];
                best_src = SRC_W'(i);
            end
        end
        if (trap_in) begin
            found    = 1'b1;
            best_src = TRAP_IDX;
        end
        if (nmi_in) begin
            found    = 1'b1;
            best_src = NMI_IDX;
        end
        grant_now  = tick_reg && !ibusy_reg && found;
        ibusy_next = grant_now || (ibusy_reg && !irq_done_in);
        src_next   = grant_now ? best_src : src_reg;
        vec_next   = grant_now ? VEC_BASE + VEC_STEP * 24'(best_src) : vec_reg;
    end
    always_ff @(posedge sys_clk_in) begin
        if (hold) begin
            ibusy_reg <= 1'b0;
            grant_reg <= 1'b0;
            src_reg   <= '0;
            vec_reg   <= 24'h000000;
        end else begin
            ibusy_reg <= ibusy_next;
            grant_reg <= grant_now;
            src_reg   <= src_next;
            vec_reg   <= vec_next;
        end
    end

    // instruction fetch sequencer
    casf_fetch_type fst_reg, fst_next;
    logic [2:0]  fcnt_reg, fcnt_next, need_reg, need_next;
    logic [23:0] faddr_reg, faddr_next;
    logic [15:0] page_reg, page_next, instr_reg, instr_next;
    logic        page_ok_reg, page_ok_next, crd_reg, crd_next, erd_reg, erd_next;
    logic        ival_reg, ival_next, two_reg, two_next, f_onchip, f_hit, f_start;
    always_comb begin
        f_onchip     = (fetch_addr_in[23:16] == CODE_REGION);
        f_hit        = page_mode_in && page_ok_reg && (fetch_addr_in[23:8] == page_reg);
        f_start      = (fst_reg == F_IDLE) && tick_reg && fetch_req_in && !grant_now;
        fst_next     = fst_reg;
        fcnt_next    = fcnt_reg;
        need_next    = need_reg;
        faddr_next   = faddr_reg;
        page_next    = page_reg;
        page_ok_next = page_ok_reg;
        crd_next     = crd_reg;
        erd_next     = erd_reg;
        instr_next   = instr_reg;
        two_next     = two_reg;
        ival_next    = 1'b0;
        unique case (fst_reg)
            F_IDLE: begin
                if (f_start) begin
                    fst_next     = F_BUSY;
                    need_next    = f_onchip ? FETCH_CLK_ONCHIP : (f_hit ? FETCH_CLK_HIT : FETCH_CLK_MISS);
                    fcnt_next    = need_next;
                    faddr_next   = fetch_addr_in;
                    page_next    = fetch_addr_in[23:8];
                    page_ok_next = 1'b1;
                    crd_next     = f_onchip;
                    erd_next     = !f_onchip;
                end
            end
            F_BUSY: begin
                if (grant_now) begin
                    fst_next = F_IDLE;
                    crd_next = 1'b0;
                    erd_next = 1'b0;
                end else if (tick_reg) begin
                    if (fcnt_reg == 3'h1) begin
                        fst_next   = F_IDLE;
                        crd_next   = 1'b0;
                        erd_next   = 1'b0;
                        ival_next  = 1'b1;
                        two_next   = crd_reg;
                        instr_next = crd_reg ? code_data_in : {8'h00, ext_data_in};
                    end else begin
                        fcnt_next = fcnt_reg - 3'h1;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge sys_clk_in) begin
        if (hold) begin
            fst_reg     <= F_IDLE;
            fcnt_reg    <= 3'h0;
            need_reg    <= 3'h0;
            faddr_reg   <= 24'h000000;
            page_reg    <= 16'h0000;
            page_ok_reg <= 1'b0;
            crd_reg     <= 1'b0;
            erd_reg     <= 1'b0;
            instr_reg   <= 16'h0000;
            two_reg     <= 1'b0;
            ival_reg    <= 1'b0;
        end else begin
            fst_reg     <= fst_next;
            fcnt_reg    <= fcnt_next;
            need_reg    <= need_next;
            faddr_reg   <= faddr_next;
            page_reg    <= page_next;
            page_ok_reg <= page_ok_next;
            crd_reg     <= crd_next;
            erd_reg     <= erd_next;
            instr_reg   <= instr_next;
            two_reg     <= two_next;
            ival_reg    <= ival_next;
        end
    end

    // data address decode into memory, register file and special function space
    logic [4:0]  d_sel, sel_reg; // ram, code, ext, sfr, rf
    logic [23:0] d_addr, maddr_reg;
    logic [2:0]  d_bit, bit_reg;
    logic        d_err, err_reg, dval_reg;
    always_comb begin
        d_sel  = 5'h00;
        d_addr = 24'h000000;
        d_bit  = 3'h0;
        d_err  = 1'b0;
        unique case (acc_kind_in)
            ACC_LINEAR: begin
                d_addr = acc_addr_in;
                if (acc_addr_in[23:16] == CODE_REGION) d_sel = 5'h02;
                else if (acc_addr_in < RAM_SIZE) d_sel = 5'h01;
                else d_sel = 5'h04;
            end
            ACC_REGFILE: begin
                if (rf_loc_in < RF_BANKED) begin
                    d_sel  = 5'h01;
                    d_addr = {19'h00000, psw_bank_in, rf_loc_in[2:0]};
                end else begin
                    d_sel  = 5'h10;
                    d_addr = {18'h00000, rf_loc_in};
                end
                d_err = (acc_width_in == W_WORD && rf_loc_in[0]) ||
                        (acc_width_in == W_DWORD && rf_loc_in[1:0] != 2'h0) ||
                        (acc_width_in > W_DWORD);
            end
            ACC_SFR: begin
                d_sel  = 5'h08;
                d_addr = {15'h0000, acc_addr_in[8:0]};
            end
            ACC_LEG_DIRECT: begin
                d_sel  = acc_addr_in[7] ? 5'h08 : 5'h01;
                d_addr = {16'h0000, acc_addr_in[7:0]};
            end
            ACC_LEG_INDIRECT: begin
                d_sel  = 5'h01;
                d_addr = {16'h0000, acc_addr_in[7:0]};
            end
            ACC_LEG_BIT: begin
                d_bit = acc_addr_in[2:0];
                if (acc_addr_in[7]) begin
                    d_sel  = 5'h08;
                    d_addr = {16'h0000, acc_addr_in[7:3], 3'h0};
                end else begin
                    d_sel  = 5'h01;
                    d_addr = {16'h0000, LEG_BIT_BASE + {4'h0, acc_addr_in[6:3]}};
                end
            end
            ACC_CODE_MOVE: begin
                d_sel  = 5'h02;
                d_addr = {CODE_REGION, acc_addr_in[15:0]};
            end
            ACC_EXT_MOVE: begin
                d_sel  = 5'h04;
                d_addr = {dpx_region_in, acc_addr_in[15:0]};
            end
        endcase
    end
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            dval_reg  <= 1'b0;
            sel_reg   <= 5'h00;
            maddr_reg <= 24'h000000;
            bit_reg   <= 3'h0;
            err_reg   <= 1'b0;
        end else begin
            dval_reg  <= dec_req_in;
            sel_reg   <= d_sel;
            maddr_reg <= d_addr;
            bit_reg   <= d_bit;
            err_reg   <= d_err;
        end
    end

    // outputs straight from registers
    assign core_tick_out   = tick_reg;
    assign phase_out       = phase_reg;
    assign state_num_out   = state_reg;
    assign core_rst_out    = core_rst_reg;
    assign fetch_addr_out  = faddr_reg;
    assign code_rd_out     = crd_reg;
    assign ext_rd_out      = erd_reg;
    assign instr_out       = instr_reg;
    assign instr_valid_out = ival_reg;
    assign instr_two_out   = two_reg;
    assign dec_valid_out   = dval_reg;
    assign {sel_rf_out, sel_sfr_out, sel_ext_out, sel_code_out, sel_ram_out} = sel_reg;
    assign map_addr_out    = maddr_reg;
    assign bit_pos_out     = bit_reg;
    assign map_err_out     = err_reg;
    assign irq_grant_out   = grant_reg;
    assign irq_src_out     = src_reg;
    assign irq_vec_out     = vec_reg;

    // helper: core ticks seen during the current fetch
    logic [2:0] h_ticks_reg;
    always_ff @(posedge sys_clk_in) begin
        if (hold || f_start) h_ticks_reg <= 3'h0;
        else if (tick_reg && fst_reg == F_BUSY) h_ticks_reg <= h_ticks_reg + 3'h1;
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_onchip_start;
        !core_rst_out && f_start && f_onchip;
    endsequence
    sequence s_miss_start;
        !core_rst_out && f_start && !f_onchip && !f_hit;
    endsequence

    a_wdt_reset: assert property (wdt_expire_in |=> core_rst_out)
        else $error("watchdog expiry did not reset the core");
    a_state_range: assert property (state_num_out >= STATE_FIRST && state_num_out <= STATE_LAST)
        else $error("state number outside one to six");
    a_pcyc_wrap: assert property (!core_rst_out && core_tick_out && phase_out && state_num_out == STATE_LAST
        |=> state_num_out == STATE_FIRST)
        else $error("peripheral cycle did not wrap after six states");
    a_phase_toggle: assert property (!core_rst_out && core_tick_out |=> phase_out != $past(phase_out))
        else $error("phase did not advance on core clock");
    a_fetch_time: assert property (instr_valid_out |-> h_ticks_reg == need_reg)
        else $error("fetch took wrong number of core clocks");
    a_miss_slow: assert property (s_miss_start |=> need_reg == FETCH_CLK_MISS && ext_rd_out)
        else $error("page miss fetch not four clocks");
    a_onchip_fast: assert property (s_onchip_start |=> need_reg == FETCH_CLK_ONCHIP && code_rd_out)
        else $error("on-chip fetch not one state");
    a_fetch_width: assert property (instr_valid_out |-> instr_two_out == (fetch_addr_out[23:16] == CODE_REGION))
        else $error("fetch width does not match source");
    a_bank_map: assert property (dec_req_in && acc_kind_in == ACC_REGFILE && rf_loc_in < RF_BANKED
        |=> sel_ram_out && map_addr_out == {19'h00000, $past(psw_bank_in), $past(rf_loc_in[2:0])})
        else $error("banked register not mapped to selected bank");
    a_legacy_hi: assert property (acc_kind_in == ACC_LEG_DIRECT && acc_addr_in[7]
        |=> sel_sfr_out && !sel_ram_out)
        else $error("legacy direct upper address did not select register space");
    a_nmi_grant: assert property (!core_rst_out && core_tick_out && nmi_in && !ibusy_reg
        |=> irq_grant_out && irq_src_out == NMI_IDX)
        else $error("non-maskable request not granted");
    a_grant_abort: assert property (irq_grant_out |-> !code_rd_out && !ext_rd_out)
        else $error("fetch continued after grant");
endmodule
`default_nettype wire

// ---- casf_mem_model.sv ----
// casf_mem_model: code memory and external program memory behind the fetch unit
// assumes read data is wanted in the same clock as the read strobes
`default_nettype none
module casf_mem_model (
    // clock
    input  wire logic        sys_clk_in,
    // fetch side
    input  wire logic        code_rd_in,
    input  wire logic        ext_rd_in,
    input  wire logic [23:0] addr_in,
    // data back
    output logic      [15:0] code_data_out,
    output logic      [7:0]  ext_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] junk_reg = 8'h00;
    // idle lines show a pattern that changes every cycle
    always @(posedge sys_clk_in) junk_reg <= junk_reg + 8'h01;
    // on-chip word carries two bytes, external memory one byte
    always_comb begin
        code_data_out = code_rd_in ? {~addr_in[7:0], addr_in[7:0]} : {junk_reg, ~junk_reg};
        ext_data_out  = ext_rd_in ? (addr_in[7:0] ^ 8'h3C) : junk_reg;
    end
endmodule
`default_nettype wire

// ---- casf_core_bench.sv ----
// casf_core_bench: self-checking bench for clocking, fetch, decode, interrupts and reset
// assumes casf_pkg, casf_core and casf_mem_model are compiled before it
`default_nettype none
module casf_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import casf_pkg::*;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, rst_pin_n_in = 1'b1, wdt_expire_in = 1'b0, page_mode_in = 1'b0;
    logic fetch_req_in = 1'b0, dec_req_in = 1'b0, trap_in = 1'b0, nmi_in = 1'b0, irq_done_in = 1'b0;
    logic [7:0] presc_div_in = 8'h00, dpx_region_in = 8'h01, irq_in = 8'h00, irq_en_in = 8'h00;
    logic [23:0] fetch_addr_in = 24'h000000, acc_addr_in = 24'h000000;
    logic [15:0] irq_prio_in = 16'h0000;
    logic [5:0] rf_loc_in = 6'h00;
    logic [1:0] acc_width_in = W_BYTE, psw_bank_in = 2'h2;
    casf_acc_type acc_kind_in = ACC_LINEAR;
    logic [15:0] code_data_in, instr_out;
    logic [7:0] ext_data_in;
    logic core_tick_out, phase_out, core_rst_out, code_rd_out, ext_rd_out, instr_valid_out, instr_two_out;
    logic dec_valid_out, sel_ram_out, sel_code_out, sel_ext_out, sel_sfr_out, sel_rf_out, map_err_out, irq_grant_out;
    logic [2:0] state_num_out, bit_pos_out;
    logic [3:0] irq_src_out;
    logic [23:0] fetch_addr_out, map_addr_out, irq_vec_out;
    int failures = 0, checks_done = 0;

    // design and memory model
    casf_core u_dut (.sys_clk_in, .rst_n_in, .rst_pin_n_in, .wdt_expire_in, .presc_div_in, .core_tick_out,
        .phase_out, .state_num_out, .core_rst_out, .page_mode_in, .fetch_req_in, .fetch_addr_in, .code_data_in,
        .ext_data_in, .fetch_addr_out, .code_rd_out, .ext_rd_out, .instr_out, .instr_valid_out, .instr_two_out,
        .dec_req_in, .acc_kind_in, .acc_addr_in, .rf_loc_in, .acc_width_in, .psw_bank_in, .dpx_region_in,
        .dec_valid_out, .sel_ram_out, .sel_code_out, .sel_ext_out, .sel_sfr_out, .sel_rf_out, .map_addr_out,
        .bit_pos_out, .map_err_out, .irq_in, .irq_en_in, .irq_prio_in, .trap_in, .nmi_in, .irq_done_in,
        .irq_grant_out, .irq_src_out, .irq_vec_out);
    casf_mem_model u_mem (.sys_clk_in, .code_rd_in(code_rd_out), .ext_rd_in(ext_rd_out), .addr_in(fetch_addr_out),
        .code_data_out(code_data_in), .ext_data_out(ext_data_in));

    // 100 MHz clock
    always #5 sys_clk_in = ~sys_clk_in;

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic stop_test;
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    // ticks three clocks apart, phase alternates, state steps 1..6 after phase two
    task automatic t_clock;
        logic [2:0] ps;
        logic pp;
        int gap, n;
        presc_div_in = 8'h02;
        n = 0; gap = 0; ps = 3'h1; pp = 1'b0;
        while (n < 16) begin
            cyc(1); gap++;
            if (core_tick_out === 1'b1) begin
                if (n > 1) begin
                    chk(gap == 3, "tick spacing");
                    chk(phase_out === ~pp && state_num_out === (pp ? (ps == 3'h6 ? 3'h1 : ps + 3'h1) : ps), "state");
                end
                ps = state_num_out; pp = phase_out; gap = 0; n++;
            end
        end
        presc_div_in = 8'h00;
        cyc(4);
    endtask

    // one fetch at one tick per clock; n ticks to valid
    task automatic fetch(input logic [23:0] a, input int n, input logic [15:0] d, input logic two);
        int k;
        cyc(1);
        fetch_addr_in = a; fetch_req_in = 1'b1; k = 0;
        do begin cyc(1); k++; fetch_req_in = 1'b0; end while (instr_valid_out !== 1'b1 && k < 20);
        chk(k == n + 1, "fetch latency");
        chk(instr_out === d && instr_two_out === two, "fetch data");
    endtask

    // decode one access; sel is {ram, code, ext, sfr, rf}
    task automatic dec(input casf_acc_type kd, input logic [23:0] a, input logic [5:0] l, input logic [1:0] w,
                       input logic [4:0] s, input logic [23:0] m, input logic e);
        acc_kind_in = kd; acc_addr_in = a; rf_loc_in = l; acc_width_in = w; dec_req_in = 1'b1;
        cyc(1);
        dec_req_in = 1'b0;
        chk(dec_valid_out === 1'b1 && map_err_out === e, "decode valid");
        if (e === 1'b0) chk({sel_ram_out, sel_code_out, sel_ext_out, sel_sfr_out, sel_rf_out} === s && map_addr_out === m,
                            "decode target");
    endtask

    // wait for a grant, check source and vector, then finish service
    task automatic grant(input logic [3:0] s);
        int k;
        k = 0;
        do begin cyc(1); k++; end while (irq_grant_out !== 1'b1 && k < 8);
        chk(irq_grant_out === 1'b1 && irq_src_out === s && irq_vec_out === 24'hFF0000 + {17'h0, s, 3'h0}, "grant");
        nmi_in = 1'b0; trap_in = 1'b0; irq_in = 8'h00; irq_done_in = 1'b1;
        cyc(1);
        irq_done_in = 1'b0;
    endtask

    task automatic t_irq;
        int k, v;
        nmi_in = 1'b1; trap_in = 1'b1; irq_in = 8'hFF; irq_en_in = 8'hFF; irq_prio_in = 16'hFFFF;
        grant(4'h8);
        irq_en_in = 8'h00; trap_in = 1'b1; irq_in = 8'hFF;
        grant(4'h9);
        irq_en_in = 8'h24; irq_prio_in = 16'h3810; irq_in = 8'h64;
        grant(4'h5);
        irq_in = 8'h40; v = 0;
        for (k = 0; k < 10; k++) begin cyc(1); if (irq_grant_out === 1'b1) v++; end
        chk(v == 0, "masked source granted");
        irq_in = 8'h00; page_mode_in = 1'b0;
        // grant in mid-fetch abandons it
        fetch_addr_in = 24'h010020; fetch_req_in = 1'b1;
        cyc(1);
        chk(ext_rd_out === 1'b1, "fetch not started");
        fetch_req_in = 1'b0; nmi_in = 1'b1;
        // the grant is a single pulse: take it and finish service before watching the fetch
        grant(4'h8);
        v = 0;
        for (k = 0; k < 8; k++) begin cyc(1); if (instr_valid_out === 1'b1) v++; end
        chk(v == 0 && ext_rd_out === 1'b0 && irq_src_out === 4'h8, "fetch not abandoned");
    endtask

    task automatic t_reset;
        wdt_expire_in = 1'b1;
        cyc(1);
        wdt_expire_in = 1'b0;
        chk(core_rst_out === 1'b1, "watchdog reset");
        cyc(4);
        rst_pin_n_in = 1'b0;
        cyc(4);
        chk(core_rst_out === 1'b1, "pin reset");
        rst_pin_n_in = 1'b1;
        cyc(6);
        chk(core_rst_out === 1'b0, "reset not released");
    endtask

    // watchdog against a hang
    initial begin
        #30000;
        failures++;
        stop_test;
    end

    initial begin
        cyc(20);
        rst_n_in = 1'b1;
        cyc(8);
        t_clock;
        fetch(24'hFF1234, 2, 16'hCB34, 1'b1);
        fetch(24'h010010, 4, 16'h002C, 1'b0);
        fetch(24'h010011, 4, 16'h002D, 1'b0);
        page_mode_in = 1'b1;
        fetch(24'h010012, 2, 16'h002E, 1'b0);
        fetch(24'h0201FF, 4, 16'h00C3, 1'b0);
        fetch(24'h020200, 4, 16'h003C, 1'b0);
        fetch(24'h020201, 2, 16'h003D, 1'b0);
        dec(ACC_REGFILE, 24'h0, 6'h03, W_BYTE, 5'b10000, 24'h000013, 1'b0);
        dec(ACC_REGFILE, 24'h0, 6'h09, W_BYTE, 5'b00001, 24'h000009, 1'b0);
        dec(ACC_REGFILE, 24'h0, 6'h05, W_WORD, 5'b00000, 24'h0, 1'b1);
        dec(ACC_REGFILE, 24'h0, 6'h08, W_DWORD, 5'b00001, 24'h000008, 1'b0);
        dec(ACC_REGFILE, 24'h0, 6'h0A, W_DWORD, 5'b00000, 24'h0, 1'b1);
        dec(ACC_REGFILE, 24'h0, 6'h08, 2'h3, 5'b00000, 24'h0, 1'b1);
        dec(ACC_LINEAR, 24'hFF0042, 6'h0, W_BYTE, 5'b01000, 24'hFF0042, 1'b0);
        dec(ACC_LINEAR, 24'h00001F, 6'h0, W_BYTE, 5'b10000, 24'h00001F, 1'b0);
        dec(ACC_LINEAR, 24'h7F0000, 6'h0, W_BYTE, 5'b00100, 24'h7F0000, 1'b0);
        dec(ACC_SFR, 24'h0001FF, 6'h0, W_BYTE, 5'b00010, 24'h0001FF, 1'b0);
        dec(ACC_LEG_DIRECT, 24'h000090, 6'h0, W_BYTE, 5'b00010, 24'h000090, 1'b0);
        dec(ACC_LEG_DIRECT, 24'h00007F, 6'h0, W_BYTE, 5'b10000, 24'h00007F, 1'b0);
        dec(ACC_LEG_INDIRECT, 24'h000090, 6'h0, W_BYTE, 5'b10000, 24'h000090, 1'b0);
        dec(ACC_LEG_BIT, 24'h00007F, 6'h0, W_BYTE, 5'b10000, 24'h00002F, 1'b0);
        chk(bit_pos_out === 3'h7, "bit position");
        dec(ACC_CODE_MOVE, 24'h001234, 6'h0, W_BYTE, 5'b01000, 24'hFF1234, 1'b0);
        dec(ACC_EXT_MOVE, 24'h005678, 6'h0, W_BYTE, 5'b00100, 24'h015678, 1'b0);
        t_irq;
        t_reset;
        stop_test;
    end
endmodule
`default_nettype wire
